//--- pkg/iomcd_pkg.sv
// Constants, types and reset state for the I/O multiplexor command unit
package iomcd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_AWL = 8'h00;
    localparam logic [7:0] OFS_AWH = 8'h04;
    localparam logic [7:0] OFS_DWL = 8'h08;
    localparam logic [7:0] OFS_DWH = 8'h0c;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_RSPL = 8'h18;
    localparam logic [7:0] OFS_RSPH = 8'h1c;
    localparam logic [7:0] OFS_MUXID = 8'h20;
    localparam logic [7:0] OFS_CTL = 8'h24;
    // Address word fields
    localparam int AW_M = 0;
    localparam int AW_Z_LSB = 1;
    localparam int AW_F_LSB = 5;
    localparam int AW_UNIT_LSB = 9;
    localparam int AW_IRQSEL = 9;
    // Multiplexor selector codes
    localparam logic [1:0] Z_MUX_A = 2'h1;
    localparam logic [1:0] Z_MUX_B = 2'h2;
    localparam logic [1:0] MUX_ID_RST = 2'h1;
    // Area descriptor and control word fields
    localparam int AD_LEN_LSB = 20;
    localparam int CW_STD_LSB = 36;
    localparam int CW_AUX = 32;
    // Result descriptor fields
    localparam int RD_ADDR_LSB = 28;
    localparam int RD_UNIT_LSB = 17;
    localparam int RD_PROT = 16;
    localparam int RD_UERR_LSB = 9;
    localparam int RD_CCARD = 10;
    localparam int RD_PAR_B = 9;
    localparam int RD_RCHK = 8;
    localparam int RD_PAR_A = 7;
    localparam int RD_DESC = 4;
    // Function codes
    localparam logic [3:0] F_OUT_START = 4'h0;
    localparam logic [3:0] F_OUT_TOD = 4'h3;
    localparam logic [3:0] F_OUT_MASK = 4'h4;
    localparam logic [3:0] F_IN_PATH = 4'h0;
    localparam logic [3:0] F_IN_STAT = 4'h1;
    localparam logic [3:0] F_IN_RES = 4'h2;
    localparam logic [3:0] F_IN_TOD = 4'h3;
    localparam logic [3:0] F_IN_IRQ = 4'h4;
    localparam logic [3:0] F_IN_KIND = 4'h6;
    localparam logic [3:0] F_IN_LIT = 4'hf;
    // Peripheral control kinds
    localparam logic [1:0] K_READER = 2'h1;
    localparam logic [1:0] K_PUNCH = 2'h2;
    localparam logic [1:0] K_CONSOLE = 2'h3;
    // Sequencer states, Gray along idle-fetch-run-done
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_FETCH = 2'h1, ST_RUN = 2'h3, ST_DONE = 2'h2} iomcd_state_t;
    // Standard control field, bit 45 first
    typedef struct packed {
        logic attn; logic rd; logic minh; logic xlat; logic frame8;
        logic mprot; logic back; logic test; logic [1:0] tag;
    } iomcd_ctl_t;
    // Completion report from a peripheral control
    typedef struct packed {
        logic [19:0] final_addr; logic prot_err; logic [6:0] unit_err;
        logic [6:0] std_err; logic read_chk; logic ctl_card; logic par_err;
    } iomcd_done_t;
    // Whole state of the unit
    typedef struct packed {
        iomcd_state_t state; logic waitreq; logic [31:0] rdata;
        logic [47:0] addr_w; logic [47:0] data_w; logic [1:0] mux_id;
        logic [47:0] tod; logic [47:0] irq_mask; logic fin; logic [7:0] irq_lit;
        logic [47:0] result; logic [47:0] resp; logic mem_req; logic [19:0] mem_addr;
        logic [47:0] ctlw; logic [7:0] unit; logic pc_start; logic aux;
        logic [7:0] xl_byte; logic xl_vld; logic busy_err; logic ignored;
    } iomcd_st_t;
    localparam iomcd_st_t ST_RST = '{state: ST_IDLE, waitreq: 1'b1, mux_id: MUX_ID_RST, default: '0};
endpackage

//--- src/iomcd_top.sv
// Command decoder, control-word fetch and result descriptor builder of an I/O multiplexor
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Command is address word plus data word
// - Broadcast flag zero: every multiplexor acts
// - Select flag one: only named multiplexor acts
// - Selector 01 is first, 10 second
// - Initiate fetches control word at area base
// - Control word: standard 45-36, unit 35-0
// - Decode standard control bits from 45 down
// - Read/write and frame length bit polarities
// - Function code from address bits 8-5
// - Scan-out 0000 initiates, unit in 16-9
// - Scan-out 0011 clock, 0100 mask load
// - Scan-in 0000 path, 0001 status, 0010 result
// - Scan-in 0011,0100,0110,1111 read values
// - Completion sets finish flag, result held
// - Final memory address in bits 47-28
// - Error field: standard plus unit 15-9
// - Standard error bits 16 and 6-0
// - Reader: read check 8, control card 10
// - Card bytes pass through unconverted, binary untouched
// - Punch bit 32 selects auxiliary stacker
// - Console parity error sets result bits 7,9
module iomcd_top
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Memory fetch port
    output logic mem_req,
    output logic [19:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [47:0] mem_rdata,
    // Peripheral control side
    output logic pc_start,
    output logic [7:0] pc_unit,
    output var iomcd_pkg::iomcd_ctl_t pc_ctl,
    output logic [35:0] pc_unit_ctl,
    output logic pc_aux_stacker,
    input wire logic [1:0] pc_kind,
    input wire logic pc_done,
    input wire iomcd_pkg::iomcd_done_t pc_res,
    input wire logic [47:0] pc_status,
    // Card byte path
    input wire logic [7:0] pc_byte,
    input wire logic pc_byte_vld,
    output logic [7:0] xl_byte,
    output logic xl_vld,
    // Finish flag
    output logic io_finish
);

    // Registered state and its next value
    iomcd_pkg::iomcd_st_t s;
    iomcd_pkg::iomcd_st_t next_s;
    // Bus request accepted this cycle
    logic acc;
    // Write and read strobes
    logic wr;
    logic rd;
    // Command decode helpers
    logic hit;
    logic go_out;
    logic go_in;
    logic fin_set;
    logic fin_clr;
    logic [3:0] code;
    logic [1:0] zsel;
    // Decoded standard control of the held word
    iomcd_pkg::iomcd_ctl_t ctl;
    // Result being assembled
    logic [47:0] res_v;

    // Byte-lane merge for a 32-bit register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Next-state logic
    always_comb
    begin
        next_s = s;
        res_v = '0;
        fin_set = 1'b0;
        fin_clr = 1'b0;
        go_out = 1'b0;
        go_in = 1'b0;
        // Request taken only while waitrequest is high
        acc = (avs_read | avs_write) & s.waitreq;
        wr = acc & avs_write;
        rd = acc & avs_read;
        // One wait cycle, then a single ready cycle
        next_s.waitreq = ~acc;
        // Code and selector from the latched address word
        code = s.addr_w[iomcd_pkg::AW_F_LSB +: 4];
        zsel = s.addr_w[iomcd_pkg::AW_Z_LSB +: 2];
        // Broadcast reaches all, selection needs a used matching code
        if (!s.addr_w[iomcd_pkg::AW_M])
        begin
            hit = 1'b1;
        end
        else if ((zsel == iomcd_pkg::Z_MUX_A) || (zsel == iomcd_pkg::Z_MUX_B))
        begin
            hit = (zsel == s.mux_id);
        end
        else
        begin
            hit = 1'b0;
        end
        // Control word fields
        ctl = iomcd_pkg::iomcd_ctl_t'(s.ctlw[iomcd_pkg::CW_STD_LSB +: 10]);
        // Start pulse lasts one cycle
        next_s.pc_start = 1'b0;
        // Time of day runs between loads
        next_s.tod = s.tod + 48'h1;
        // Sequencer
        case (s.state)
            iomcd_pkg::ST_FETCH:
            begin
                // Wait for the control word from memory
                if (mem_ack)
                begin
                    next_s.mem_req = 1'b0;
                    next_s.ctlw = mem_rdata;
                    if (s.data_w[iomcd_pkg::AD_LEN_LSB +: 20] == 20'h0)
                    begin
                        // Empty area: finish at once with a descriptor error
                        res_v[iomcd_pkg::RD_UNIT_LSB +: 8] = s.unit;
                        res_v[iomcd_pkg::RD_DESC] = 1'b1;
                        next_s.result = res_v;
                        next_s.state = iomcd_pkg::ST_DONE;
                    end
                    else
                    begin
                        // Hand the operation to the peripheral control
                        next_s.pc_start = 1'b1;
                        next_s.aux = (pc_kind == iomcd_pkg::K_PUNCH) && mem_rdata[iomcd_pkg::CW_AUX];
                        next_s.state = iomcd_pkg::ST_RUN;
                    end
                end
            end
            iomcd_pkg::ST_RUN:
            begin
                // Build the result descriptor on completion
                if (pc_done)
                begin
                    res_v[iomcd_pkg::RD_ADDR_LSB +: 20] = pc_res.final_addr;
                    res_v[iomcd_pkg::RD_UNIT_LSB +: 8] = s.unit;
                    res_v[iomcd_pkg::RD_PROT] = pc_res.prot_err;
                    res_v[iomcd_pkg::RD_UERR_LSB +: 7] = pc_res.unit_err;
                    res_v[6:0] = pc_res.std_err;
                    if (pc_kind == iomcd_pkg::K_READER)
                    begin
                        // Control card only exists on alpha reads
                        res_v[iomcd_pkg::RD_RCHK] = pc_res.read_chk;
                        res_v[iomcd_pkg::RD_CCARD] = pc_res.ctl_card & ctl.xlat;
                    end
                    else if ((pc_kind == iomcd_pkg::K_CONSOLE) && pc_res.par_err)
                    begin
                        // Parity shows as a pair of bits
                        res_v[iomcd_pkg::RD_PAR_A] = 1'b1;
                        res_v[iomcd_pkg::RD_PAR_B] = 1'b1;
                    end
                    next_s.result = res_v;
                    next_s.state = iomcd_pkg::ST_DONE;
                end
            end
            iomcd_pkg::ST_DONE:
            begin
                // Raise the finish flag and record the unit
                fin_set = 1'b1;
                next_s.irq_lit = s.unit;
                next_s.aux = 1'b0;
                next_s.state = iomcd_pkg::ST_IDLE;
            end
            default:
            begin
                // Idle: nothing outstanding
                next_s.state = iomcd_pkg::ST_IDLE;
            end
        endcase
        // Card byte path: both codes share 8-bit values here, binary untouched
        next_s.xl_vld = pc_byte_vld && (s.state == iomcd_pkg::ST_RUN);
        next_s.xl_byte = pc_byte;
        // Register writes
        if (wr)
        begin
            if (avs_address == iomcd_pkg::OFS_AWL)
            begin
                next_s.addr_w[31:0] = merge(s.addr_w[31:0], avs_writedata, avs_byteenable);
            end
            else if (avs_address == iomcd_pkg::OFS_AWH)
            begin
                next_s.addr_w[47:32] = 16'(merge({16'h0, s.addr_w[47:32]}, avs_writedata, avs_byteenable));
            end
            else if (avs_address == iomcd_pkg::OFS_DWL)
            begin
                next_s.data_w[31:0] = merge(s.data_w[31:0], avs_writedata, avs_byteenable);
            end
            else if (avs_address == iomcd_pkg::OFS_DWH)
            begin
                next_s.data_w[47:32] = 16'(merge({16'h0, s.data_w[47:32]}, avs_writedata, avs_byteenable));
            end
            else if (avs_address == iomcd_pkg::OFS_CMD)
            begin
                // Command goes only to an addressed multiplexor
                go_out = hit & avs_byteenable[0] & avs_writedata[0];
                go_in = hit & avs_byteenable[0] & avs_writedata[1] & ~avs_writedata[0];
                next_s.ignored = ~hit;
            end
            else if (avs_address == iomcd_pkg::OFS_STAT)
            begin
                // Write one to bit 2 clears the busy error
                if (avs_byteenable[0] && avs_writedata[2])
                begin
                    next_s.busy_err = 1'b0;
                end
            end
            else if (avs_address == iomcd_pkg::OFS_MUXID)
            begin
                // Own selector identity
                if (avs_byteenable[0])
                begin
                    next_s.mux_id = avs_writedata[1:0];
                end
            end
        end
        // Scan-out execution
        if (go_out)
        begin
            if (code == iomcd_pkg::F_OUT_START)
            begin
                if (s.state == iomcd_pkg::ST_IDLE)
                begin
                    // Fetch the control word from the area base
                    next_s.unit = s.addr_w[iomcd_pkg::AW_UNIT_LSB +: 8];
                    next_s.mem_addr = s.data_w[19:0];
                    next_s.mem_req = 1'b1;
                    next_s.state = iomcd_pkg::ST_FETCH;
                end
                else
                begin
                    // Path in use: refuse and flag it
                    next_s.busy_err = 1'b1;
                end
            end
            else if (code == iomcd_pkg::F_OUT_TOD)
            begin
                next_s.tod = s.data_w;
            end
            else if (code == iomcd_pkg::F_OUT_MASK)
            begin
                next_s.irq_mask = s.data_w;
            end
        end
        // Scan-in execution, answer lands in the response register
        if (go_in)
        begin
            case (code)
                iomcd_pkg::F_IN_PATH:
                begin
                    next_s.resp = {47'h0, s.state == iomcd_pkg::ST_IDLE};
                end
                iomcd_pkg::F_IN_STAT:
                begin
                    next_s.resp = pc_status;
                end
                iomcd_pkg::F_IN_RES:
                begin
                    // Reading the result releases the finish flag
                    next_s.resp = s.result;
                    fin_clr = 1'b1;
                end
                iomcd_pkg::F_IN_TOD:
                begin
                    next_s.resp = s.tod;
                end
                iomcd_pkg::F_IN_IRQ:
                begin
                    // Address bit 9 picks mask over flags
                    if (s.addr_w[iomcd_pkg::AW_IRQSEL])
                    begin
                        next_s.resp = s.irq_mask;
                    end
                    else
                    begin
                        next_s.resp = {47'h0, s.fin};
                    end
                end
                iomcd_pkg::F_IN_KIND:
                begin
                    next_s.resp = {46'h0, pc_kind};
                end
                iomcd_pkg::F_IN_LIT:
                begin
                    next_s.resp = {40'h0, s.irq_lit};
                end
                default:
                begin
                    // Unused codes answer zero
                    next_s.resp = 48'h0;
                end
            endcase
        end
        // A new finish beats a clear in the same cycle
        next_s.fin = (s.fin & ~fin_clr) | fin_set;
        // Register reads
        if (rd)
        begin
            if (avs_address == iomcd_pkg::OFS_AWL)
            begin
                next_s.rdata = s.addr_w[31:0];
            end
            else if (avs_address == iomcd_pkg::OFS_AWH)
            begin
                next_s.rdata = {16'h0, s.addr_w[47:32]};
            end
            else if (avs_address == iomcd_pkg::OFS_DWL)
            begin
                next_s.rdata = s.data_w[31:0];
            end
            else if (avs_address == iomcd_pkg::OFS_DWH)
            begin
                next_s.rdata = {16'h0, s.data_w[47:32]};
            end
            else if (avs_address == iomcd_pkg::OFS_STAT)
            begin
                next_s.rdata = {22'h0, s.mux_id, 2'h0, s.state, s.ignored, s.busy_err, s.fin,
                                s.state != iomcd_pkg::ST_IDLE};
            end
            else if (avs_address == iomcd_pkg::OFS_RSPL)
            begin
                next_s.rdata = s.resp[31:0];
            end
            else if (avs_address == iomcd_pkg::OFS_RSPH)
            begin
                next_s.rdata = {16'h0, s.resp[47:32]};
            end
            else if (avs_address == iomcd_pkg::OFS_MUXID)
            begin
                next_s.rdata = {30'h0, s.mux_id};
            end
            else if (avs_address == iomcd_pkg::OFS_CTL)
            begin
                next_s.rdata = {22'h0, ctl};
            end
            else
            begin
                // Unmapped and write-only offsets read zero
                next_s.rdata = 32'h0;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s <= iomcd_pkg::ST_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign mem_req = s.mem_req;
    assign mem_addr = s.mem_addr;
    assign pc_start = s.pc_start;
    assign pc_unit = s.unit;
    assign pc_ctl = iomcd_pkg::iomcd_ctl_t'(s.ctlw[iomcd_pkg::CW_STD_LSB +: 10]);
    assign pc_unit_ctl = s.ctlw[35:0];
    assign pc_aux_stacker = s.aux;
    assign xl_byte = s.xl_byte;
    assign xl_vld = s.xl_vld;
    assign io_finish = s.fin;

    // Broadcast mask load reaches this multiplexor
    property p_bcast;
        @(posedge clk_sys) disable iff (rst)
        (go_out && !s.addr_w[iomcd_pkg::AW_M] && code == iomcd_pkg::F_OUT_MASK) |=> (s.irq_mask == $past(s.data_w));
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast mask load missed");

    // Other multiplexor's mask load leaves ours alone
    property p_sel;
        @(posedge clk_sys) disable iff (rst)
        (wr && avs_address == iomcd_pkg::OFS_CMD && s.addr_w[iomcd_pkg::AW_M] && zsel != s.mux_id)
        |=> s.ignored && $stable(s.irq_mask);
    endproperty
    a_sel: assert property (p_sel) else $error("unselected multiplexor acted");

    // Unused selector code never starts an operation
    property p_unused;
        @(posedge clk_sys) disable iff (rst)
        (wr && avs_address == iomcd_pkg::OFS_CMD && s.state == iomcd_pkg::ST_IDLE
         && s.addr_w[iomcd_pkg::AW_M] && (zsel == 2'h0 || zsel == 2'h3))
        |=> (s.state == iomcd_pkg::ST_IDLE) && s.ignored;
    endproperty
    a_unused: assert property (p_unused) else $error("unused selector accepted");

    // Fetch addresses the area base until memory answers
    property p_fetch;
        @(posedge clk_sys) disable iff (rst)
        (s.state == iomcd_pkg::ST_FETCH) |-> mem_req && (mem_addr == s.data_w[19:0]);
    endproperty
    a_fetch: assert property (p_fetch) else $error("control word fetch address wrong");

    // Start pulse carries the unit designation
    property p_start;
        @(posedge clk_sys) disable iff (rst)
        pc_start |-> (pc_unit == s.addr_w[iomcd_pkg::AW_UNIT_LSB +: 8]) ##1 !pc_start;
    endproperty
    a_start: assert property (p_start) else $error("start pulse or unit wrong");

    // Completion raises the finish flag two cycles later
    property p_fin;
        @(posedge clk_sys) disable iff (rst)
        (s.state == iomcd_pkg::ST_RUN && pc_done) |-> ##2 io_finish;
    endproperty
    a_fin: assert property (p_fin) else $error("finish flag not raised");

    // Final address lands in the top field
    property p_addr;
        @(posedge clk_sys) disable iff (rst)
        (s.state == iomcd_pkg::ST_RUN && pc_done) |=>
        (s.result[iomcd_pkg::RD_ADDR_LSB +: 20] == $past(pc_res.final_addr));
    endproperty
    a_addr: assert property (p_addr) else $error("final address misplaced");

    // Console parity error shows in both bits
    property p_par;
        @(posedge clk_sys) disable iff (rst)
        (s.state == iomcd_pkg::ST_RUN && pc_done && pc_kind == iomcd_pkg::K_CONSOLE && pc_res.par_err)
        |=> s.result[iomcd_pkg::RD_PAR_A] && s.result[iomcd_pkg::RD_PAR_B];
    endproperty
    a_par: assert property (p_par) else $error("console parity bits missing");

    // Punch bit 32 drives the auxiliary stacker select
    property p_aux;
        @(posedge clk_sys) disable iff (rst)
        (s.state == iomcd_pkg::ST_FETCH && mem_ack && pc_kind == iomcd_pkg::K_PUNCH)
        |=> (pc_aux_stacker == ($past(mem_rdata[iomcd_pkg::CW_AUX]) && pc_start));
    endproperty
    a_aux: assert property (p_aux) else $error("stacker select wrong");

    // Reading the result returns it and drops the flag
    property p_res;
        @(posedge clk_sys) disable iff (rst)
        (go_in && code == iomcd_pkg::F_IN_RES && s.state != iomcd_pkg::ST_DONE) |=>
        (s.resp == $past(s.result)) && !io_finish;
    endproperty
    a_res: assert property (p_res) else $error("result read wrong");

endmodule
`default_nettype wire

//--- bench/iomcd_far.sv
// Memory and peripheral-control model facing the command unit
`timescale 1ns/1ps
`default_nettype none
module iomcd_far
(
    // Clock
    input wire logic clk_sys,
    // Memory side
    input wire logic mem_req,
    output logic mem_ack,
    output logic [47:0] mem_rdata,
    // Peripheral side
    input wire logic pc_start,
    output logic pc_done,
    output var iomcd_pkg::iomcd_done_t pc_res,
    // Values and delay set by the bench, delay at least 1
    input wire logic [47:0] cw,
    input wire iomcd_pkg::iomcd_done_t res,
    input wire logic [3:0] dly
);
    logic [3:0] mcnt = 4'h0, pcnt = 4'h0;
    // Slow or prompt answers; data lines show the inverse when not acknowledging
    always_ff @(posedge clk_sys)
    begin
        mem_ack <= mem_req && !mem_ack && mcnt == dly;
        mcnt <= (mem_req && !mem_ack && mcnt != dly) ? mcnt + 4'h1 : 4'h0;
        mem_rdata <= (mcnt == dly) ? cw : ~cw;
        pcnt <= pc_start ? 4'h1 : ((pcnt == dly || pcnt == 4'h0) ? 4'h0 : pcnt + 4'h1);
        pc_done <= pcnt == dly;
        pc_res <= (pcnt == dly) ? res : ~res;
    end
endmodule
`default_nettype wire

//--- bench/iomcd_top_tb.sv
// Self-checking bench of the command unit
`timescale 1ns/1ps
`default_nettype none
module iomcd_top_tb;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, mem_req, mem_ack, pc_start, pc_done;
    logic [7:0] avs_address, pc_unit, xl_byte;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable, dly;
    logic [19:0] mem_addr;
    logic [47:0] mem_rdata, pc_status, cw, rsp, v, dw, c;
    logic [35:0] pc_unit_ctl;
    logic pc_aux_stacker, io_finish, xl_vld;
    logic [1:0] pc_kind;
    iomcd_pkg::iomcd_ctl_t pc_ctl;
    iomcd_pkg::iomcd_done_t pc_res, res;
    int err_count, n_compared;
    iomcd_top dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .pc_start, .pc_unit,
        .pc_ctl, .pc_unit_ctl, .pc_aux_stacker, .pc_kind, .pc_done, .pc_res, .pc_status,
        .pc_byte(cw[7:0]), .pc_byte_vld(pc_done), .xl_byte, .xl_vld, .io_finish);
    iomcd_far far (.clk_sys, .mem_req, .mem_ack, .mem_rdata, .pc_start, .pc_done, .pc_res, .cw, .res, .dly);
    // Verdict and end of run
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Hang cut short
    task automatic hang;
        err_count++;
        $display("unexpected at %0t: wait ran out", $time);
        end_sim();
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 40) hang();
            @(posedge clk_sys);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Address word from function, flag, selector and unit
    function automatic logic [47:0] aw(logic [3:0] f, logic m, logic [1:0] z, logic [7:0] u);
        return {31'h0, u, f, 2'h0, z, m};
    endfunction
    // Expected result descriptor
    function automatic logic [47:0] exp_rd(iomcd_pkg::iomcd_done_t r, logic [7:0] u, logic [1:0] k, logic x);
        logic [47:0] e;
        e = {r.final_addr, 3'h0, u, r.prot_err, r.unit_err, 2'h0, r.std_err};
        e[8] = e[8] | (k == iomcd_pkg::K_READER && r.read_chk);
        e[10] = (k == iomcd_pkg::K_READER) ? (x && r.ctl_card) : e[10];
        e[9] = e[9] | r.par_err;
        e[7] = r.par_err;
        return e;
    endfunction
    // Load both words, issue a scan, read the answer
    task automatic scan(input logic [47:0] a, input logic [47:0] d, input logic [1:0] c);
        bus(1'b1, iomcd_pkg::OFS_AWL, a[31:0]);
        bus(1'b1, iomcd_pkg::OFS_AWH, {16'h0, a[47:32]});
        bus(1'b1, iomcd_pkg::OFS_DWL, d[31:0]);
        bus(1'b1, iomcd_pkg::OFS_DWH, {16'h0, d[47:32]});
        bus(1'b1, iomcd_pkg::OFS_CMD, {30'h0, c});
        bus(1'b0, iomcd_pkg::OFS_RSPL, 32'h0);
        rsp[31:0] = q;
        bus(1'b0, iomcd_pkg::OFS_RSPH, 32'h0);
        rsp[47:32] = q[15:0];
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        iomcd_pkg::iomcd_done_t r;
        logic [7:0] u;
        logic [1:0] k;
        int n;
        {avs_read, avs_write, avs_address, avs_writedata, pc_kind, cw, res} = '0;
        {rst, avs_byteenable, dly, err_count, n_compared} = {1'b1, 4'hf, 4'h1, 64'h0};
        void'($urandom(31));
        pc_status = 48'($urandom);
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, iomcd_pkg::OFS_MUXID, 32'h0);
        chk(q, 64'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 64'h0);
        scan(aw(iomcd_pkg::F_IN_PATH, 1'b0, 2'h0, 8'h00), 48'h0, 2'h2);
        chk(rsp, 64'h1);
        scan(aw(iomcd_pkg::F_IN_STAT, 1'b0, 2'h0, 8'h00), 48'h0, 2'h2);
        chk(rsp, pc_status);
        for (int i = 0; i < 8; i++)
        begin
            k = 2'($urandom);
            u = 8'($urandom);
            c = 48'({$urandom, $urandom});
            r = 38'({$urandom, $urandom});
            r.par_err = r.par_err && k == iomcd_pkg::K_CONSOLE;
            dw = {8'h00, (i == 0) ? 20'h0 : 20'($urandom_range(99, 1)), 20'($urandom)};
            cw <= c;
            res <= r;
            pc_kind <= k;
            dly <= 4'($urandom_range(9, 6));
            scan(aw(iomcd_pkg::F_OUT_START, i[0], 2'h1, u), dw, 2'h1);
            n = 0;
            while (io_finish !== 1'b1)
            begin
                if (mem_req === 1'b1) chk(mem_addr, dw[19:0]);
                if (pc_start === 1'b1) chk({pc_aux_stacker, pc_ctl, pc_unit, pc_unit_ctl}, {k == 2'h2 && c[32], c[45:36], u, c[35:0]});
                if (xl_vld === 1'b1) chk(xl_byte, c[7:0]);
                n++;
                if (n > 300) hang();
                @(posedge clk_sys);
            end
            scan(aw(iomcd_pkg::F_IN_RES, 1'b0, 2'h0, 8'h00), 48'h0, 2'h2);
            chk((i == 0) ? rsp & 48'h10 : rsp, (i == 0) ? 48'h10 : exp_rd(r, u, k, c[42]));
            chk(io_finish, 1'b0);
            scan(aw(iomcd_pkg::F_IN_LIT, 1'b0, 2'h0, 8'h00), 48'h0, 2'h2);
            chk(rsp, u);
            scan(aw(iomcd_pkg::F_IN_KIND, 1'b0, 2'h0, 8'h00), 48'h0, 2'h2);
            chk(rsp, k);
        end
        v = {8'h00, $urandom, 8'h00};
        scan(aw(iomcd_pkg::F_OUT_TOD, 1'b1, 2'h1, 8'h00), v, 2'h1);
        scan(aw(iomcd_pkg::F_OUT_TOD, 1'b1, 2'h2, 8'h00), v ^ 48'h10000, 2'h1);
        scan(aw(iomcd_pkg::F_OUT_TOD, 1'b1, 2'h3, 8'h00), v ^ 48'h20000, 2'h1);
        bus(1'b0, iomcd_pkg::OFS_STAT, 32'h0);
        chk(q[3], 1'b1);
        scan(aw(iomcd_pkg::F_IN_TOD, 1'b0, 2'h0, 8'h00), 48'h0, 2'h2);
        chk(rsp & ~48'hff, v);
        scan(aw(iomcd_pkg::F_OUT_MASK, 1'b0, 2'h0, 8'h00), v, 2'h1);
        scan(aw(iomcd_pkg::F_IN_IRQ, 1'b0, 2'h0, 8'h01), 48'h0, 2'h2);
        chk(rsp, v);
        scan(aw(iomcd_pkg::F_IN_IRQ, 1'b0, 2'h0, 8'h00), 48'h0, 2'h2);
        chk(rsp, 64'h0);
        end_sim();
    end
endmodule
`default_nettype wire
